// ===== verilog/step_seq_pkg.sv
// constants and carrier types for the multi-step speed sequencer
`default_nettype none
package step_seq_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets on the apb bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_MAXFREQ = 8'h08;
  localparam logic [7:0] OFS_SAVED   = 8'h0c;
  localparam logic [7:0] OFS_SPEED   = 8'h40;
  localparam logic [7:0] OFS_TIME    = 8'h80;
  localparam logic [7:0] TABLE_MASK  = 8'hc0;

  // decoded register kinds
  localparam logic [2:0] KIND_NONE   = 3'h0;
  localparam logic [2:0] KIND_CTRL   = 3'h1;
  localparam logic [2:0] KIND_STATUS = 3'h2;
  localparam logic [2:0] KIND_MAXF   = 3'h3;
  localparam logic [2:0] KIND_SAVED  = 3'h4;
  localparam logic [2:0] KIND_SPEED  = 3'h5;
  localparam logic [2:0] KIND_TIME   = 3'h6;

  // ---------------------------------------------------------------
  // settings and value ranges
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_ONCE   = 2'h0;
  localparam logic [1:0]  MODE_HOLD   = 2'h1;
  localparam logic [1:0]  MODE_CYCLE  = 2'h2;
  localparam logic [3:0]  LAST_STEP   = 4'hf;
  localparam logic [3:0]  FIRST_STEP  = 4'h0;
  // speeds are signed tenths of a percent: 1000 is 100.0 %
  localparam logic signed [15:0] SPEED_MAX = 16'sh03e8;
  localparam logic signed [15:0] SPEED_MIN = -16'sh03e8;
  localparam logic [31:0] PCT_FULL    = 32'h0000_03e8;
  localparam logic [15:0] MAXF_RST    = 16'h1388;
  localparam logic [15:0] ZERO16      = 16'h0000;

  // ---------------------------------------------------------------
  // time base: running times count in tenths of the chosen unit
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TENTH_SEC_MS  = 100;
  localparam int TENTH_MIN_MS  = 6000;
  localparam int TENTH_SEC_CYC = TENTH_SEC_MS * (1000000 / CLK_PERIOD_NS);
  localparam int TENTH_MIN_CYC = TENTH_MIN_MS * (1000000 / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       terminal_sel;
    logic       time_unit_min;
    logic       retain;
    logic [1:0] mode;
  } ctrl_t;

  typedef struct packed {
    logic [15:0][15:0] speed;
    logic [15:0][15:0] run_time;
    ctrl_t             ctrl;
    logic [15:0]       max_freq;
    logic              running;
    logic              holding;
    logic              done;
    logic [3:0]        stage;
    logic [15:0]       elapsed;
    logic              saved_valid;
    logic [3:0]        saved_stage;
    logic [15:0]       saved_elapsed;
    logic [15:0]       saved_freq;
    logic [15:0]       freq_out;
    logic              dir_rev;
    logic [31:0]       prdata;
  } seq_state_t;

  typedef struct packed {
    logic [31:0] count;
  } tick_state_t;

endpackage
`default_nettype wire

// ===== verilog/step_tick.sv
// tenth-of-unit tick generator for step running times
`default_nettype none
module step_tick
#(
  parameter int SEC_CYC = step_seq_pkg::TENTH_SEC_CYC,
  parameter int MIN_CYC = step_seq_pkg::TENTH_MIN_CYC
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic unit_min,
  output logic      tick
);

  step_seq_pkg::tick_state_t st_r;
  step_seq_pkg::tick_state_t st_nxt;
  logic [31:0]               limit;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb
  begin
    limit  = unit_min ? 32'(MIN_CYC - 1) : 32'(SEC_CYC - 1);
    st_nxt = st_r;
    tick   = 1'b0;
    // restart on every step change so each step gets whole tenths
    if (clear)
    begin
      st_nxt.count = '0;
    end
    else if (st_r.count >= limit)
    begin
      st_nxt.count = '0;
      tick         = 1'b1;
    end
    else
    begin
      st_nxt.count = st_r.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/multi_step_speed_sequencer.sv
// multi-step speed sequencer with apb register file
//
// What this block does
// - mode 0 runs the sequence once, stops, waits for new run command.
// - mode 1 keeps final step frequency and direction after one pass.
// - mode 2 restarts the sequence after each pass until stopped.
// - retention 0 forgets the position at power loss; restart at step 0.
// - retention 1 saves stage and frequency at power loss, resumes there.
// - each speed setpoint spans -100.0 to 100.0 percent of max frequency.
// - each running time spans 0.0 to 6553.5 seconds or minutes.
// - each timed step uses its own speed and running time pair.
// - setpoint sign picks direction: positive forward, negative reverse.
// - terminal mode decodes four step inputs as a binary setpoint index.
// - terminal codes 0 to 15 map one to one onto setpoints 0 to 15.
//
// Local design decisions: register access over APB and the placing of the registers.
`default_nettype none
module multi_step_speed_sequencer
#(
  parameter int SEC_CYC = step_seq_pkg::TENTH_SEC_CYC,
  parameter int MIN_CYC = step_seq_pkg::TENTH_MIN_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        run_cmd,
  input  wire logic        stop_cmd,
  input  wire logic [3:0]  step_sel,
  input  wire logic        power_fail,
  output logic      [15:0] freq_out,
  output logic             dir_rev,
  output logic             running,
  output logic      [3:0]  stage
);

  step_seq_pkg::seq_state_t st_r;
  step_seq_pkg::seq_state_t st_nxt;
  logic                     tick;
  logic                     tick_clear;
  logic                     timed;
  logic                     expire;
  logic [2:0]               kind;
  logic [15:0]              sel_speed;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] reg_kind(input logic [7:0] a);
    logic [2:0] k;
    k = step_seq_pkg::KIND_NONE;
    if (a[1:0] == 2'h0)
    begin
      if ((a & step_seq_pkg::TABLE_MASK) == step_seq_pkg::OFS_SPEED)
        k = step_seq_pkg::KIND_SPEED;
      else if ((a & step_seq_pkg::TABLE_MASK) == step_seq_pkg::OFS_TIME)
        k = step_seq_pkg::KIND_TIME;
      else if (a == step_seq_pkg::OFS_CTRL)
        k = step_seq_pkg::KIND_CTRL;
      else if (a == step_seq_pkg::OFS_STATUS)
        k = step_seq_pkg::KIND_STATUS;
      else if (a == step_seq_pkg::OFS_MAXFREQ)
        k = step_seq_pkg::KIND_MAXF;
      else if (a == step_seq_pkg::OFS_SAVED)
        k = step_seq_pkg::KIND_SAVED;
    end
    return k;
  endfunction

  // magnitude of a setpoint scaled onto the max output frequency
  function automatic logic [15:0] to_freq(input logic [15:0] spd,
                                          input logic [15:0] mf);
    logic [15:0] mag;
    logic [31:0] prod;
    mag  = spd[15] ? 16'(-spd) : spd;
    prod = 32'(mag) * 32'(mf);
    return 16'(prod / step_seq_pkg::PCT_FULL);
  endfunction

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  step_tick #(
    .SEC_CYC (SEC_CYC),
    .MIN_CYC (MIN_CYC)
  ) u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (tick_clear),
    .unit_min (st_r.ctrl.time_unit_min),
    .tick     (tick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt     = st_r;
    kind       = reg_kind(paddr);
    timed      = st_r.running && !st_r.ctrl.terminal_sel && !st_r.holding;
    expire     = timed && (st_r.elapsed >= st_r.run_time[st_r.stage]);
    tick_clear = 1'b0;

    // apb write takes effect at the access edge
    if (psel && penable && pwrite)
    begin
      case (kind)
        step_seq_pkg::KIND_CTRL:
          st_nxt.ctrl = pwdata[4:0];
        step_seq_pkg::KIND_MAXF:
          st_nxt.max_freq = pwdata[15:0];
        step_seq_pkg::KIND_SPEED:
        begin
          // out-of-range setpoints are clamped to full scale
          if ($signed(pwdata) > $signed(32'(step_seq_pkg::SPEED_MAX)))
            st_nxt.speed[paddr[5:2]] = step_seq_pkg::SPEED_MAX;
          else if ($signed(pwdata) < $signed(32'(step_seq_pkg::SPEED_MIN)))
            st_nxt.speed[paddr[5:2]] = step_seq_pkg::SPEED_MIN;
          else
            st_nxt.speed[paddr[5:2]] = pwdata[15:0];
        end
        step_seq_pkg::KIND_TIME:
          st_nxt.run_time[paddr[5:2]] = pwdata[15:0];
        default:
          st_nxt.prdata = st_r.prdata;
      endcase
    end

    // read data captured in the setup cycle, so prdata is a flop
    if (psel && !penable)
    begin
      case (kind)
        step_seq_pkg::KIND_CTRL:
          st_nxt.prdata = {27'h0, st_r.ctrl};
        step_seq_pkg::KIND_STATUS:
          st_nxt.prdata = {st_r.freq_out, 6'h0, st_r.saved_valid,
                           st_r.dir_rev, st_r.stage, 1'b0, st_r.done,
                           st_r.holding, st_r.running};
        step_seq_pkg::KIND_MAXF:
          st_nxt.prdata = {16'h0, st_r.max_freq};
        step_seq_pkg::KIND_SAVED:
          st_nxt.prdata = {st_r.saved_freq, 12'h0, st_r.saved_stage};
        step_seq_pkg::KIND_SPEED:
          st_nxt.prdata = 32'($signed(st_r.speed[paddr[5:2]]));
        step_seq_pkg::KIND_TIME:
          st_nxt.prdata = {16'h0, st_r.run_time[paddr[5:2]]};
        default:
          st_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // sequencing: stop and power loss win over everything else
    if (power_fail || stop_cmd)
    begin
      st_nxt.running = 1'b0;
      st_nxt.holding = 1'b0;
      if (power_fail && st_r.running && st_r.ctrl.retain)
      begin
        st_nxt.saved_valid   = 1'b1;
        st_nxt.saved_stage   = st_r.stage;
        st_nxt.saved_elapsed = st_r.elapsed;
        st_nxt.saved_freq    = st_r.freq_out;
      end
      else if (power_fail && !st_r.ctrl.retain)
      begin
        st_nxt.saved_valid = 1'b0;
      end
    end
    else if (run_cmd && !st_r.running)
    begin
      // a run while already running is ignored
      st_nxt.running = 1'b1;
      st_nxt.done    = 1'b0;
      tick_clear     = 1'b1;
      if (st_r.ctrl.retain && st_r.saved_valid)
      begin
        st_nxt.stage   = st_r.saved_stage;
        st_nxt.elapsed = st_r.saved_elapsed;
      end
      else
      begin
        st_nxt.stage   = step_seq_pkg::FIRST_STEP;
        st_nxt.elapsed = step_seq_pkg::ZERO16;
      end
      st_nxt.saved_valid = 1'b0;
    end
    else if (expire)
    begin
      tick_clear     = 1'b1;
      st_nxt.elapsed = step_seq_pkg::ZERO16;
      if (st_r.stage != step_seq_pkg::LAST_STEP)
      begin
        st_nxt.stage = st_r.stage + 4'h1;
      end
      else
      begin
        case (st_r.ctrl.mode)
          step_seq_pkg::MODE_ONCE:
          begin
            st_nxt.running = 1'b0;
            st_nxt.done    = 1'b1;
          end
          step_seq_pkg::MODE_HOLD:
            st_nxt.holding = 1'b1;
          step_seq_pkg::MODE_CYCLE:
            st_nxt.stage = step_seq_pkg::FIRST_STEP;
          default:
          begin
            // unused mode code behaves as run-once
            st_nxt.running = 1'b0;
            st_nxt.done    = 1'b1;
          end
        endcase
      end
    end
    else if (timed && tick)
    begin
      st_nxt.elapsed = st_r.elapsed + 16'h0001;
    end

    // output frequency and direction
    sel_speed = st_r.ctrl.terminal_sel ? st_r.speed[step_sel]
                                       : st_r.speed[st_r.stage];
    if (st_r.running)
    begin
      st_nxt.freq_out = to_freq(sel_speed, st_r.max_freq);
      st_nxt.dir_rev  = sel_speed[15];
    end
    else
    begin
      st_nxt.freq_out = step_seq_pkg::ZERO16;
      st_nxt.dir_rev  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r          <= '0;
      st_r.max_freq <= step_seq_pkg::MAXF_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero-wait slave: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (kind == step_seq_pkg::KIND_NONE);
  assign prdata   = st_r.prdata;
  assign freq_out = st_r.freq_out;
  assign dir_rev  = st_r.dir_rev;
  assign running  = st_r.running;
  assign stage    = st_r.stage;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic quiet;
  assign quiet = !stop_cmd && !power_fail;

  AST_ONCE_STOPS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (expire && quiet && st_r.stage == step_seq_pkg::LAST_STEP &&
     st_r.ctrl.mode == step_seq_pkg::MODE_ONCE)
    |=> (!st_r.running && st_r.done) ##1 (!st_r.running || $past(run_cmd)))
    else $error("run-once did not stop after last step");

  AST_HOLD_LAST: assert property (
    @(posedge pclk) disable iff (!presetn)
    (expire && quiet && st_r.stage == step_seq_pkg::LAST_STEP &&
     st_r.ctrl.mode == step_seq_pkg::MODE_HOLD)
    |=> st_r.running && st_r.holding &&
        st_r.stage == step_seq_pkg::LAST_STEP)
    else $error("hold mode left the last step");

  AST_CYCLE_WRAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (expire && quiet && st_r.stage == step_seq_pkg::LAST_STEP &&
     st_r.ctrl.mode == step_seq_pkg::MODE_CYCLE)
    |=> st_r.running && st_r.stage == step_seq_pkg::FIRST_STEP)
    else $error("cyclic mode did not wrap to step 0");

  AST_NO_RETAIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_cmd && quiet && !st_r.running && !st_r.ctrl.retain)
    |=> st_r.stage == step_seq_pkg::FIRST_STEP && st_r.elapsed == 16'h0000)
    else $error("start without retention not at step 0");

  AST_RETAIN_SAVE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (power_fail && st_r.running && st_r.ctrl.retain)
    |=> st_r.saved_valid && !st_r.running &&
        st_r.saved_stage == $past(st_r.stage) &&
        st_r.saved_freq == $past(st_r.freq_out))
    else $error("stage not saved at power loss");

  AST_SPEED_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && kind == step_seq_pkg::KIND_SPEED)
    |=> $signed(st_r.speed[$past(paddr[5:2])]) <= step_seq_pkg::SPEED_MAX &&
        $signed(st_r.speed[$past(paddr[5:2])]) >= step_seq_pkg::SPEED_MIN)
    else $error("stored setpoint outside full scale");

  AST_DIRECTION: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.running |=> st_r.dir_rev == $past(sel_speed[15]))
    else $error("direction does not follow setpoint sign");

  AST_TERMINAL: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r.running && st_r.ctrl.terminal_sel)
    |=> st_r.freq_out == to_freq($past(st_r.speed[step_sel]),
                                 $past(st_r.max_freq)))
    else $error("terminal code chose the wrong setpoint");

  AST_ADVANCE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (expire && quiet && st_r.stage != step_seq_pkg::LAST_STEP)
    |=> st_r.stage == $past(st_r.stage) + 4'h1 && st_r.elapsed == 16'h0000)
    else $error("step did not advance on expiry");

endmodule
`default_nettype wire

// ===== testbench/step_cmd_source.sv
// model of the input terminals and the run command source
`default_nettype none
module step_cmd_source
(
  input  wire logic       pclk,
  output var  logic       run_cmd,
  output var  logic       stop_cmd,
  output var  logic       power_fail,
  output var  logic [3:0] step_sel
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    run_cmd    = 1'b0;
    stop_cmd   = 1'b0;
    power_fail = 1'b0;
    step_sel   = 4'h0;
  end

  // -------------------------------------------------------------
  // commands
  // -------------------------------------------------------------
  // start, stop and power loss each travel on their own command line
  // one-cycle pulses: a held level would restart a finished pass
  task pulse(input int which);
    @(posedge pclk);
    run_cmd    <= (which == 0);
    stop_cmd   <= (which == 1);
    power_fail <= (which == 2);
    @(posedge pclk);
    run_cmd    <= 1'b0;
    stop_cmd   <= 1'b0;
    power_fail <= 1'b0;
  endtask

  // terminals hold their level like a wired switch
  task set_code(input logic [3:0] c);
    @(posedge pclk);
    step_sel <= c;
  endtask
endmodule
`default_nettype wire

// ===== testbench/multi_step_speed_sequencer_tb_top.sv
// self-checking testbench for the multi-step speed sequencer
`default_nettype none
module multi_step_speed_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        run_cmd;
  logic        stop_cmd;
  logic        power_fail;
  logic [3:0]  step_sel;
  logic [15:0] freq_out;
  logic        dir_rev;
  logic        running;
  logic [3:0]  stage;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          checked   = 0;

  always #50 pclk = ~pclk;

  // short tick so a whole pass takes tens of cycles
  multi_step_speed_sequencer #(.SEC_CYC(4), .MIN_CYC(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
    .stop_cmd(stop_cmd), .step_sel(step_sel), .power_fail(power_fail),
    .freq_out(freq_out), .dir_rev(dir_rev), .running(running),
    .stage(stage));

  step_cmd_source u_src (
    .pclk(pclk), .run_cmd(run_cmd), .stop_cmd(stop_cmd),
    .power_fail(power_fail), .step_sel(step_sel));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task stop_test;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      bad_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait: what 0 waits for stage s, 1 for running low
  task wait_for(input int what, input logic [3:0] s);
    int n;
    n = 0;
    while (!(what == 0 ? stage === s : running === 1'b0) && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  // odd steps reverse so both directions are exercised
  function automatic logic [31:0] sp(input int i);
    return (i % 2) ? -(10 * i + 5) : (10 * i + 5);
  endfunction

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task t_reset;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_1388);
    for (int i = 0; i < 16; i += 15)
    begin
      apb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h80 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset values done");
  endtask

  task t_range;
    apb(1'b1, 8'h40, 32'h0000_07d0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0000_03e8);
    apb(1'b1, 8'h40, 32'hffff_f830);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'hffff_fc18);
    apb(1'b1, 8'h80, 32'h0000_ffff);
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0000_ffff);
    apb(1'b1, 8'h80, 32'h0);
    apb(1'b1, 8'h10, 32'h0000_00aa);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("value ranges done");
  endtask

  task t_term;
    apb(1'b1, 8'h08, 32'h0000_03e8);
    for (int i = 0; i < 16; i++)
      apb(1'b1, 8'h40 + 8'(4 * i), sp(i));
    apb(1'b1, 8'h00, 32'h0000_0010);
    u_src.pulse(0);
    for (int i = 0; i < 16; i++)
    begin
      u_src.set_code(4'(i));
      repeat (3) @(posedge pclk);
      chk(32'(freq_out), 32'(10 * i + 5));
      chk(32'(dir_rev), 32'(i % 2));
    end
    u_src.pulse(1);
    $display("terminal select done");
  endtask

  task t_seq(input logic [1:0] m);
    int n;
    int lo;
    // cyclic mode runs in minutes so both time units are exercised
    lo = (m == 2'h2) ? 40 : 20;
    apb(1'b1, 8'h00, {28'h0, m == 2'h2, 1'b0, m});
    u_src.pulse(0);
    wait_for(0, 4'h3);
    n = 0;
    while (stage === 4'h3 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    // five ticks of four or eight cycles plus the advance cycle
    chk(32'(n >= lo && n <= lo + 2), 32'h1);
    wait_for(0, 4'hf);
    // unused mode code 3 must behave as run-once
    if (m == 2'h0 || m == 2'h3)
    begin
      wait_for(1, 4'h0);
      repeat (5) @(posedge pclk);
      chk({running, 15'h0, freq_out}, 32'h0);
    end
    else if (m == 2'h1)
    begin
      repeat (30) @(posedge pclk);
      chk({stage, 3'h0, running, 8'h0, freq_out}, 32'hf100_009b);
      chk(32'(dir_rev), 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h009b_01f3);
    end
    else
    begin
      wait_for(0, 4'h0);
      chk(32'(running), 32'h1);
    end
    u_src.pulse(1);
    repeat (3) @(posedge pclk);
    $display("sequence mode %0d done", m);
  endtask

  task t_keep(input logic r);
    apb(1'b1, 8'h00, {29'h0, r, 2'h0});
    u_src.pulse(0);
    wait_for(0, 4'h5);
    repeat (5) @(posedge pclk);
    u_src.pulse(2);
    repeat (3) @(posedge pclk);
    chk(32'(running), 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, r ? 32'h0037_0005 : 32'h0);
    u_src.pulse(0);
    repeat (3) @(posedge pclk);
    chk({stage, 12'h0, freq_out}, r ? 32'h5000_0037 : 32'h0000_0005);
    u_src.pulse(1);
    repeat (3) @(posedge pclk);
    $display("retention %0d done", r);
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_range();
    t_term();
    apb(1'b1, 8'h8c, 32'h0000_0005);
    for (int m = 0; m < 4; m++)
      t_seq(2'(m));
    // long step five so power loss lands in mid-step
    apb(1'b1, 8'h94, 32'h0000_0064);
    // long step zero so a fresh start still shows step zero
    apb(1'b1, 8'h80, 32'h0000_0064);
    t_keep(1'b0);
    t_keep(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
